// file: core/pmt_defs.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH
`define PMT_OFS_CONTROL 12'hFCA
`define PMT_OFS_COUNT 12'hFCB
`define PMT_OFS_PERIOD 12'hFCC
`define PMT_OFS_IRQ_STATUS 12'hFCD
`define PMT_OFS_IRQ_MASK 12'hFCE
`define PMT_OFS_SPI_SEL 12'hFCF
`define PMT_CTL_PRESC_LSB 0
`define PMT_CTL_ON_BIT 2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_WMASK 8'h7F
`define PMT_RST_COUNT 8'h00
`define PMT_RST_PERIOD 8'hFF
`define PMT_RST_CONTROL 8'h00
`define PMT_DIV1_LAST 4'h0
`define PMT_DIV4_LAST 4'h3
`define PMT_DIV16_LAST 4'hF
`endif

// file: core/pmt_pkg.sv
// Types shared by the period match timer.
package pmt_pkg;
	typedef enum logic [1:0]
	{
		PMT_PRE_DIV1 = 2'b00,
		PMT_PRE_DIV4 = 2'b01,
		PMT_PRE_DIV16A = 2'b10,
		PMT_PRE_DIV16B = 2'b11
	} pmt_presc_t;
	typedef struct packed
	{
		logic [7:0] count;
		logic [7:0] period;
		logic [6:0] control;
		logic [3:0] presc;
		logic [3:0] post;
		logic match_d;
		logic match_pulse;
		logic irq_flag;
		logic irq_mask;
		logic spi_sel;
		logic [7:0] rdata;
	} pmt_state_t;
endpackage

// file: core/pmt_timer.sv
// Eight-bit period match timer with prescaler, postscaler and interrupt.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`include "pmt_defs.svh"
module pmt_timer
	import pmt_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_pwm_base,
	output logic o_spi_shift_clk
);
	// Narrower buses cannot reach the register offsets.
	if (ADDR_W < 12)
	begin : g_addr_w_check
		$error("ADDR_W must be at least 12");
	end

	pmt_state_t st_r;
	pmt_state_t st_nxt;

	function automatic logic [3:0] presc_last(input logic [1:0] sel);
		case (pmt_presc_t'(sel))
			PMT_PRE_DIV1: presc_last = `PMT_DIV1_LAST;
			PMT_PRE_DIV4: presc_last = `PMT_DIV4_LAST;
			default: presc_last = `PMT_DIV16_LAST;
		endcase
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [11:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	logic wr_ctl, wr_cnt, wr_per, wr_sts, wr_msk, wr_spi;
	logic on, tick, match, post_done;
	assign wr_ctl = i_wr && hit(i_addr, `PMT_OFS_CONTROL);
	assign wr_cnt = i_wr && hit(i_addr, `PMT_OFS_COUNT);
	assign wr_per = i_wr && hit(i_addr, `PMT_OFS_PERIOD);
	assign wr_sts = i_wr && hit(i_addr, `PMT_OFS_IRQ_STATUS);
	assign wr_msk = i_wr && hit(i_addr, `PMT_OFS_IRQ_MASK);
	assign wr_spi = i_wr && hit(i_addr, `PMT_OFS_SPI_SEL);
	assign on = st_r.control[`PMT_CTL_ON_BIT];
	assign tick = on && (st_r.presc ==
		presc_last(st_r.control[`PMT_CTL_PRESC_LSB +: 2]));
	assign match = (st_r.count == st_r.period);
	assign post_done = (st_r.post == st_r.control[`PMT_CTL_POST_LSB +: 4]);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.match_pulse = 1'b0;
		if (tick)
		begin
			st_nxt.presc = 4'h0;
			if (match)
			begin
				st_nxt.count = 8'h00;
				st_nxt.match_pulse = 1'b1;
			end
			else
				st_nxt.count = st_r.count + 8'h01;
			st_nxt.match_d = match;
			if (match)
			begin
				if (post_done)
				begin
					st_nxt.post = 4'h0;
					st_nxt.irq_flag = 1'b1;
				end
				else
					st_nxt.post = st_r.post + 4'h1;
			end
		end
		else if (on)
			st_nxt.presc = st_r.presc + 4'h1;
		if (wr_per)
			st_nxt.period = i_wdata;
		if (wr_cnt || wr_ctl)
		begin
			st_nxt.presc = 4'h0;
			st_nxt.post = 4'h0;
		end
		if (wr_cnt)
			st_nxt.count = i_wdata;
		if (wr_ctl)
			st_nxt.control = i_wdata[6:0];
		if (wr_sts && i_wdata[0] && !(tick && match && post_done))
			st_nxt.irq_flag = 1'b0;
		if (wr_msk)
			st_nxt.irq_mask = i_wdata[0];
		if (wr_spi)
			st_nxt.spi_sel = i_wdata[0];
		st_nxt.rdata = 8'h00;
		if (i_rd)
		begin
			if (hit(i_addr, `PMT_OFS_CONTROL))
				st_nxt.rdata = {1'b0, st_r.control};
			else if (hit(i_addr, `PMT_OFS_COUNT))
				st_nxt.rdata = st_r.count;
			else if (hit(i_addr, `PMT_OFS_PERIOD))
				st_nxt.rdata = st_r.period;
			else if (hit(i_addr, `PMT_OFS_IRQ_STATUS))
				st_nxt.rdata = {7'h00, st_r.irq_flag};
			else if (hit(i_addr, `PMT_OFS_IRQ_MASK))
				st_nxt.rdata = {7'h00, st_r.irq_mask};
			else if (hit(i_addr, `PMT_OFS_SPI_SEL))
				st_nxt.rdata = {7'h00, st_r.spi_sel};
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			st_r <= '0;
			st_r.count <= `PMT_RST_COUNT;
			st_r.period <= `PMT_RST_PERIOD;
			st_r.control <= 7'(`PMT_RST_CONTROL);
		end
		else
			st_r <= st_nxt;
	end

	assign o_rdata = st_r.rdata;
	assign o_irq = st_r.irq_flag && st_r.irq_mask;
	assign o_pwm_base = st_r.match_pulse;
	assign o_spi_shift_clk = st_r.spi_sel && st_r.match_pulse;

	a_reload_zero: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && match && !wr_cnt |=> st_r.count == 8'h00)
		else $error("count did not reload to zero after match");

	a_count_up: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && !match && !wr_cnt
		|=> st_r.count == $past(st_r.count) + 8'h01)
		else $error("count did not advance on tick");

	a_off_holds: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!on && !wr_cnt && !wr_ctl |=> $stable(st_r.count)
		&& $stable(st_r.presc))
		else $error("timer moved while off");

	a_pulse_single: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		o_pwm_base && !(tick && match) |=> !o_pwm_base)
		else $error("match pulse longer than one cycle");

	a_ctl_keeps: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_ctl && !tick |=> st_r.count == $past(st_r.count)
		&& st_r.presc == 4'h0 && st_r.post == 4'h0)
		else $error("control write disturbed count or kept scalers");

	a_irq_masked: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		o_irq |-> st_r.irq_mask && st_r.irq_flag)
		else $error("interrupt raised while masked");

	a_flag_set: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && match && post_done |=> st_r.irq_flag)
		else $error("flag not set at postscale completion");

	a_bit7_zero: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		i_rd && hit(i_addr, `PMT_OFS_CONTROL) |=> o_rdata[7] == 1'b0)
		else $error("control bit 7 read as one");

	a_presc_div: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick |-> (st_r.control[1] ? st_r.presc == `PMT_DIV16_LAST :
		st_r.control[0] ? st_r.presc == `PMT_DIV4_LAST :
		st_r.presc == `PMT_DIV1_LAST))
		else $error("prescaler tick at wrong count");

	a_reset_values: assert property (@(posedge i_clk)
		!i_resetn |=> st_r.count == `PMT_RST_COUNT
		&& st_r.period == `PMT_RST_PERIOD)
		else $error("reset did not load count and period");

	a_reset_scalers: assert property (@(posedge i_clk)
		!i_resetn |=> st_r.presc == 4'h0 && st_r.post == 4'h0)
		else $error("reset did not clear the scalers");

	a_cnt_clear: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_cnt |=> st_r.presc == 4'h0 && st_r.post == 4'h0)
		else $error("count write did not clear the scalers");

	a_cnt_load: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_cnt |=> st_r.count == $past(i_wdata))
		else $error("count write not taken");

	a_per_load: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_per |=> st_r.period == $past(i_wdata))
		else $error("period write not taken");

	a_cnt_read: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		i_rd && hit(i_addr, `PMT_OFS_COUNT)
		|=> o_rdata == $past(st_r.count))
		else $error("count read returned wrong value");

	a_per_read: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		i_rd && hit(i_addr, `PMT_OFS_PERIOD)
		|=> o_rdata == $past(st_r.period))
		else $error("period read returned wrong value");

	a_ctl_write: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_ctl |=> st_r.control == $past(i_wdata[6:0]))
		else $error("control write not taken");

	a_ctl_read: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		i_rd && hit(i_addr, `PMT_OFS_CONTROL)
		|=> o_rdata == {1'b0, $past(st_r.control)})
		else $error("control read returned wrong value");

	a_rdata_idle: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");

	a_tick_off: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!on |-> !tick)
		else $error("tick while the timer is off");

	a_presc_step: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		on && !tick && !wr_cnt && !wr_ctl
		|=> st_r.presc == $past(st_r.presc) + 4'h1)
		else $error("prescaler did not step");

	a_post_step: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && match && !post_done && !wr_cnt && !wr_ctl
		|=> st_r.post == $past(st_r.post) + 4'h1)
		else $error("postscaler did not step on match");

	a_post_hold: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!(tick && match) && !wr_cnt && !wr_ctl |=> $stable(st_r.post))
		else $error("postscaler moved without a match");

	a_post_wrap: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && match && post_done |=> st_r.post == 4'h0)
		else $error("postscaler did not wrap at selected ratio");

	a_flag_sticky: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		st_r.irq_flag && !(wr_sts && i_wdata[0]) |=> st_r.irq_flag)
		else $error("flag dropped without a clear");

	a_flag_clear: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		wr_sts && i_wdata[0] && !(tick && match && post_done)
		|=> !st_r.irq_flag)
		else $error("flag not cleared by a write of one");

	a_flag_cause: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!st_r.irq_flag ##1 st_r.irq_flag
		|-> $past(tick && match && post_done))
		else $error("flag set without postscale completion");

	a_irq_raise: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		st_r.irq_flag && st_r.irq_mask |-> o_irq)
		else $error("enabled flag gave no interrupt");

	a_pulse_cause: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		o_pwm_base |-> st_r.match_d)
		else $error("match pulse without a match");

	a_pulse_follow: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		tick && match |=> o_pwm_base)
		else $error("match gave no time base pulse");

	a_pulse_low: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!(tick && match) |=> !o_pwm_base)
		else $error("time base pulse without a match tick");

	a_spi_gate: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		o_spi_shift_clk |-> o_pwm_base && st_r.spi_sel)
		else $error("shift clock while not selected");

	a_spi_pass: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		o_pwm_base && st_r.spi_sel |-> o_spi_shift_clk)
		else $error("selected shift clock missing a pulse");

	a_count_hold: assert property (@(posedge i_clk)
		disable iff (!i_resetn)
		!tick && !wr_cnt |=> $stable(st_r.count))
		else $error("count moved without a tick");
endmodule

// file: tb/pmt_timer_tb.sv
// Register-level testbench of the period match timer.
`timescale 1ns/100ps
`include "pmt_defs.svh"
module tb;
	import pmt_pkg::*;
	logic i_clk = 1'h0, i_resetn = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00, o_rdata;
	logic o_irq, o_pwm_base, o_spi_shift_clk;
	int n_fail = 0, checks_done = 0, n, c;
	always #2 i_clk = ~i_clk;
	pmt_timer u_pmt_timer (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_irq(o_irq), .o_pwm_base(o_pwm_base),
		.o_spi_shift_clk(o_spi_shift_clk));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("mismatches %0d of %0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		#1;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1 chk(o_rdata, e);
	endtask
	// Counts cycles up to the next match pulse; a hang ends the run.
	task pulse(output int k);
		k = 0;
		do
		begin
			@(posedge i_clk);
			#1 k++;
		end while (o_pwm_base !== 1'h1 && k < 3000);
		if (k >= 3000)
		begin
			n_fail++;
			complete_run();
		end
	endtask
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'h1;
		#1;
		rd(`PMT_OFS_COUNT, 8'h00);
		rd(`PMT_OFS_PERIOD, 8'hFF);
		rd(`PMT_OFS_CONTROL, 8'h00);
		rd(12'h000, 8'h00);
		wr(`PMT_OFS_PERIOD, 8'h02);
		rd(`PMT_OFS_PERIOD, 8'h02);
		wr(`PMT_OFS_CONTROL, 8'hFF);
		rd(`PMT_OFS_CONTROL, 8'h7F);
		wr(`PMT_OFS_CONTROL, 8'h00);
		wr(`PMT_OFS_COUNT, 8'h55);
		wr(`PMT_OFS_CONTROL, 8'h78);
		rd(`PMT_OFS_COUNT, 8'h55);
		rd(`PMT_OFS_COUNT, 8'h55);
		for (int s = 0; s < 4; s++)
		begin
			wr(`PMT_OFS_COUNT, 8'h00);
			wr(`PMT_OFS_CONTROL, {1'h0, 4'h0, 1'h1, s[1:0]});
			pulse(n);
			chk(o_spi_shift_clk, 8'h00);
			pulse(n);
			chk(n[7:0], 8'((s == 0 ? 1 : s == 1 ? 4 : 16) * 3));
			@(posedge i_clk);
			#1 chk(o_pwm_base, 8'h00);
		end
		wr(`PMT_OFS_IRQ_MASK, 8'h01);
		for (int s = 0; s < 3; s++)
		begin
			n = s == 0 ? 0 : s == 1 ? 2 : 15;
			wr(`PMT_OFS_CONTROL, 8'h00);
			wr(`PMT_OFS_IRQ_STATUS, 8'h01);
			wr(`PMT_OFS_COUNT, 8'h00);
			wr(`PMT_OFS_CONTROL, {1'h0, n[3:0], 3'h4});
			c = 0;
			for (int t = 0; t < 200 && o_irq !== 1'h1; t++)
			begin
				@(posedge i_clk);
				#1 c += (o_irq !== 1'h1 && o_pwm_base === 1'h1);
			end
			chk(c[7:0], n[7:0]);
			chk(o_irq, 8'h01);
			if (o_irq !== 1'h1)
				complete_run();
		end
		wr(`PMT_OFS_CONTROL, 8'h00);
		rd(`PMT_OFS_IRQ_STATUS, 8'h01);
		wr(`PMT_OFS_IRQ_MASK, 8'h00);
		chk(o_irq, 8'h00);
		wr(`PMT_OFS_IRQ_MASK, 8'h01);
		chk(o_irq, 8'h01);
		wr(`PMT_OFS_IRQ_STATUS, 8'h01);
		chk(o_irq, 8'h00);
		wr(`PMT_OFS_SPI_SEL, 8'h01);
		wr(`PMT_OFS_COUNT, 8'h00);
		wr(`PMT_OFS_CONTROL, 8'h04);
		pulse(n);
		chk(o_spi_shift_clk, 8'h01);
		complete_run();
	end
endmodule
